/* File: logic/ext_mem_ctrl_regs.svh */
// constants for the external static memory controller
`ifndef EXT_MEM_CTRL_REGS_SVH
`define EXT_MEM_CTRL_REGS_SVH

// =============================================================
// address decode
`define REGION_MSB   27
`define REGION_LSB   26
`define REGION0      2'b00
`define ADDR_INC8    26'h000_0001
`define ADDR_INC16   26'h000_0002

// =============================================================
// transfer size and pieces
`define HSIZE_BYTE   3'h0
`define HSIZE_HALF   3'h1
`define HSIZE_WORD   3'h2
`define LAST_ONE     2'h0
`define LAST_TWO     2'h1
`define LAST_FOUR    2'h3

// =============================================================
// timing fields hold cycles minus one
`define AHLD_MIN     4'h1
`define DSET_MIN     8'h01

`endif

/* File: logic/ext_mem_pkg.sv */
// types shared by the external static memory controller
package ext_mem_pkg;

    // =========================================================
    // memory kinds
    typedef enum logic [1:0] {
        MT_SRAM  = 2'b00,
        MT_PSRAM = 2'b01,
        MT_NOR   = 2'b10,
        MT_ROM   = 2'b11
    } mem_type_t;

    // =========================================================
    // cycle sequencer
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ASET = 3'b001,
        S_AHLD = 3'b010,
        S_DSET = 3'b011,
        S_LAT  = 3'b100,
        S_ERR1 = 3'b101,
        S_ERR2 = 3'b110
    } state_t;

    // =========================================================
    // per sub-bank configuration
    typedef struct packed {
        logic      bank_en;
        mem_type_t mem_type;
        logic      width16;
        logic      mux_en;
        logic      wait_en;
        logic      wr_en;
        logic      ext_mode;
    } mem_cfg_t;

    typedef struct packed {
        logic [3:0] aset;
        logic [3:0] ahld;
        logic [7:0] dset;
        logic [3:0] buslat;
    } mem_timing_t;

endpackage : ext_mem_pkg

/* File: logic/phase_timer.sv */
// down counter timing one phase of an external cycle
`timescale 1ns/10ps

module phase_timer (
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic       load_in,
    input  wire logic [7:0] load_val_in,
    output logic            done_out
);

    logic [7:0] cnt_q;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cnt_q <= '0;
        end else if (load_in) begin
            cnt_q <= load_val_in;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    assign done_out = (cnt_q == 8'h00);

endmodule : phase_timer

/* File: logic/ext_mem_ctrl.sv */
// ahb to asynchronous static memory controller, sub-bank 0
//
// Overview of operation
// RULE1: ahb clock is the only timing reference
// RULE2: memory outputs change only on rising edge
// RULE3: memory bus width is 8 or 16
// RULE4: nor, psram, sram, rom chosen by configuration
// RULE5: equal widths give one single access
// RULE6: wider transfers split into back-to-back accesses
// RULE7: narrow uses byte lanes; no-select narrow write refused
// RULE8: four 64 MB regions, only region 0
// RULE9: address bits 27:26 pick region, 0 only
// RULE10: 8-bit memory: address 25:0 straight through
// RULE11: 16-bit memory: address 25:1 onto 24:0
// RULE12: nor/psram may multiplex address onto data bus
// RULE13: one chip select, for sub-bank 0
// RULE14: strobes, wait, lanes, buses shared; select own
// RULE15: sub-bank has own type, width, timing configuration
// RULE16: reads and writes may use separate timings
// RULE17: write strobe and byte lanes driven when needed
// RULE18: setup, hold, data, turnaround counts in clocks
// RULE19: 32-bit read on 8-bit memory is four accesses
// RULE20: wait input stretches data phase while enabled
// RULE21: select held across whole access; ahb stalled
`timescale 1ns/10ps

module ext_mem_ctrl
    import ext_mem_pkg::*;
(
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_in,
    input  wire logic                      hsel_in,
    input  wire logic [31:0]               haddr_in,
    input  wire logic [1:0]                htrans_in,
    input  wire logic                      hwrite_in,
    input  wire logic [2:0]                hsize_in,
    input  wire logic [31:0]               hwdata_in,
    input  wire logic                      hready_in,
    output logic      [31:0]               hrdata_out,
    output logic                           hreadyout_out,
    output logic                           hresp_out,
    input  wire ext_mem_pkg::mem_cfg_t     cfg_in,
    input  wire ext_mem_pkg::mem_timing_t  rd_tim_in,
    input  wire ext_mem_pkg::mem_timing_t  wr_tim_in,
    output logic      [25:0]               mem_addr_out,
    output logic      [15:0]               mem_addr_data_out,
    output logic                           mem_addr_data_oe_out,
    input  wire logic [15:0]               mem_addr_data_in,
    output logic                           sub_static_bank_sel_n_out,
    output logic                           mem_read_strobe_n_out,
    output logic                           mem_write_strobe_n_out,
    output logic                           addr_valid_n_out,
    output logic      [1:0]                mem_byte_lane_n_out,
    input  wire logic                      mem_wait_n_in
);

    `include "ext_mem_ctrl_regs.svh"

    // =========================================================
    // declarations
    state_t      state_q;
    state_t      state_d;
    mem_timing_t tim;
    logic        idle_like;
    logic        accept;
    logic        bad;
    logic        start;
    logic        narrow;
    logic        byte_sel;
    logic        mux_on;
    logic        wait_hold;
    logic        t_done;
    logic        t_load;
    logic [7:0]  t_val;
    logic [7:0]  ld_aset;
    logic [7:0]  ld_ahld;
    logic [7:0]  ld_dset;
    logic [7:0]  ld_lat;
    logic        step_piece;
    logic        capture;
    logic [1:0]  last_calc;
    logic [1:0]  last_q;
    logic [1:0]  piece_q;
    logic        write_q;
    logic        wr_d;
    logic [1:0]  size_q;
    logic [1:0]  size_d;
    logic [25:0] cur_addr_q;
    logic [25:0] addr_d;
    logic [25:0] addr_inc;
    logic [25:0] mapped;
    logic [15:0] wdata_piece;
    logic [1:0]  lane_d;
    logic [31:0] rdata_q;
    logic        act_d;

    // =========================================================
    // request decode
    assign idle_like = (state_q == S_IDLE) || (state_q == S_ERR2);
    assign accept    = idle_like && hsel_in && htrans_in[1] && hready_in;
    assign narrow    = (hsize_in == `HSIZE_BYTE) && cfg_in.width16;
    assign byte_sel  = (cfg_in.mem_type != MT_NOR); // RULE4
    // rom rejects nothing here; software keeps wr_en clear for it
    assign bad = (haddr_in[`REGION_MSB:`REGION_LSB] != `REGION0) // RULE8 RULE9
              || !cfg_in.bank_en // RULE15
              || (hsize_in > `HSIZE_WORD)
              || (hwrite_in && !cfg_in.wr_en)
              || (hwrite_in && narrow && !byte_sel); // RULE7
    assign start = accept && !bad;
    assign mux_on = cfg_in.mux_en && ((cfg_in.mem_type == MT_NOR)
                 || (cfg_in.mem_type == MT_PSRAM)); // RULE12
    assign wait_hold = cfg_in.wait_en && !mem_wait_n_in; // RULE20

    // pieces: last index depends on size against width
    always_comb begin
        case (hsize_in[1:0])
            2'b00:   last_calc = `LAST_ONE; // RULE5
            2'b01:   last_calc = cfg_in.width16 ? `LAST_ONE : `LAST_TWO;
            default: last_calc = cfg_in.width16 ? `LAST_TWO
                                                : `LAST_FOUR; // RULE19
        endcase
    end

    // =========================================================
    // timing selection
    assign wr_d = start ? hwrite_in : write_q;
    assign tim  = (wr_d && cfg_in.ext_mode) ? wr_tim_in
                                            : rd_tim_in; // RULE16
    // fields hold cycles minus one; hold and data floors enforced
    assign ld_aset = {4'h0, tim.aset}; // RULE18
    assign ld_ahld = {4'h0, (tim.ahld < `AHLD_MIN) ? `AHLD_MIN
                                                   : tim.ahld};
    assign ld_dset = (tim.dset < `DSET_MIN) ? `DSET_MIN : tim.dset;
    assign ld_lat  = {4'h0, tim.buslat};

    phase_timer u_timer (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .load_in     (t_load),
        .load_val_in (t_val),
        .done_out    (t_done)
    );

    // =========================================================
    // cycle sequencer
    always_comb begin
        state_d    = state_q;
        t_load     = 1'b0;
        t_val      = ld_aset;
        step_piece = 1'b0;
        capture    = 1'b0;
        case (state_q)
            S_IDLE, S_ERR2: begin
                if (accept && bad) begin
                    state_d = S_ERR1;
                end else if (accept) begin
                    state_d = S_ASET;
                    t_load  = 1'b1;
                end else begin
                    state_d = S_IDLE;
                end
            end
            S_ASET: begin
                if (t_done) begin
                    t_load = 1'b1;
                    if (mux_on) begin
                        state_d = S_AHLD;
                        t_val   = ld_ahld;
                    end else begin
                        state_d = S_DSET;
                        t_val   = ld_dset;
                    end
                end
            end
            S_AHLD: begin
                if (t_done) begin
                    state_d = S_DSET;
                    t_load  = 1'b1;
                    t_val   = ld_dset;
                end
            end
            S_DSET: begin
                if (t_done && !wait_hold) begin // RULE20
                    capture = !write_q;
                    if (piece_q != last_q) begin
                        // next piece follows with select still low
                        step_piece = 1'b1; // RULE6
                        state_d    = S_ASET;
                        t_load     = 1'b1;
                    end else if (!write_q) begin
                        state_d = S_LAT;
                        t_load  = 1'b1;
                        t_val   = ld_lat;
                    end else begin
                        state_d = S_IDLE;
                    end
                end
            end
            S_LAT: begin
                if (t_done) begin
                    state_d = S_IDLE;
                end
            end
            S_ERR1: begin
                state_d = S_ERR2;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin // RULE1
        if (rst_in) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // =========================================================
    // transfer bookkeeping
    assign addr_inc = cfg_in.width16 ? `ADDR_INC16 : `ADDR_INC8; // RULE3
    assign size_d   = start ? hsize_in[1:0] : size_q;

    always_comb begin
        addr_d = cur_addr_q;
        if (start) begin
            addr_d = haddr_in[25:0];
        end else if (step_piece) begin
            addr_d = cur_addr_q + addr_inc;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            write_q    <= 1'b0;
            size_q     <= 2'b00;
            last_q     <= `LAST_ONE;
            piece_q    <= 2'h0;
            cur_addr_q <= '0;
        end else begin
            write_q    <= wr_d;
            size_q     <= size_d;
            cur_addr_q <= addr_d;
            if (start) begin
                last_q  <= last_calc;
                piece_q <= 2'h0;
            end else if (step_piece) begin
                piece_q <= piece_q + 2'h1;
            end
        end
    end

    // read pieces land on the lanes their address selects
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rdata_q <= '0;
        end else if (capture && cfg_in.width16) begin
            rdata_q[{cur_addr_q[1], 4'h0} +: 16] <= mem_addr_data_in;
        end else if (capture) begin
            rdata_q[{cur_addr_q[1:0], 3'h0} +: 8] <=
                mem_addr_data_in[7:0];
        end
    end

    // =========================================================
    // ahb answer
    assign hrdata_out    = rdata_q;
    assign hreadyout_out = idle_like; // RULE21
    assign hresp_out     = (state_q == S_ERR1) || (state_q == S_ERR2);

    // =========================================================
    // memory pins, all from flops fed by the next state
    assign mapped = cfg_in.width16 ? {1'b0, addr_d[25:1]} // RULE11
                                   : addr_d; // RULE10
    // hwdata is held by the master for the whole stalled data phase
    assign wdata_piece = cfg_in.width16
                       ? hwdata_in[{addr_d[1], 4'h0} +: 16]
                       : {8'h00, hwdata_in[{addr_d[1:0], 3'h0} +: 8]};
    assign lane_d = !cfg_in.width16 ? 2'b10
                  : (size_d != 2'b00) ? 2'b00
                  : (addr_d[0] ? 2'b01 : 2'b10); // RULE7
    assign act_d = (state_d == S_ASET) || (state_d == S_AHLD)
                || (state_d == S_DSET);

    always_ff @(posedge core_clk_in) begin // RULE2
        if (rst_in) begin
            sub_static_bank_sel_n_out    <= 1'b1;
            mem_read_strobe_n_out  <= 1'b1;
            mem_write_strobe_n_out <= 1'b1;
            addr_valid_n_out       <= 1'b1;
            mem_byte_lane_n_out    <= 2'b11;
            mem_addr_out           <= '0;
            mem_addr_data_out      <= '0;
            mem_addr_data_oe_out   <= 1'b0;
        end else begin
            sub_static_bank_sel_n_out    <= !act_d; // RULE13
            mem_addr_out           <= mapped; // RULE14
            addr_valid_n_out       <= !(state_d == S_ASET);
            mem_read_strobe_n_out  <= !((state_d == S_DSET) && !wr_d);
            mem_write_strobe_n_out <= !((state_d == S_DSET)
                                        && wr_d); // RULE17
            mem_byte_lane_n_out    <= act_d ? lane_d : 2'b11;
            if (mux_on && ((state_d == S_ASET)
                           || (state_d == S_AHLD))) begin
                mem_addr_data_out    <= mapped[15:0]; // RULE12
                mem_addr_data_oe_out <= 1'b1;
            end else if ((state_d == S_DSET) && wr_d) begin
                mem_addr_data_out    <= wdata_piece;
                mem_addr_data_oe_out <= 1'b1;
            end else begin
                mem_addr_data_oe_out <= 1'b0;
            end
        end
    end

    // =========================================================
    // assertions
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    property p_region;
        accept && (haddr_in[27:26] != 2'b00)
            |=> (hresp_out && !hreadyout_out) ##1 (hresp_out && hreadyout_out);
    endproperty
    a_region: assert property (p_region) else $error("region"); // RULE9

    property p_narrow_wr;
        accept && hwrite_in && (hsize_in == 3'h0) && cfg_in.width16
            && (cfg_in.mem_type == MT_NOR) |=> state_q == S_ERR1;
    endproperty
    a_narrow_wr: assert property (p_narrow_wr) else $error("narrow"); // RULE7

    property p_addr8;
        start && !cfg_in.width16 |=> mem_addr_out == $past(haddr_in[25:0]);
    endproperty
    a_addr8: assert property (p_addr8) else $error("8-bit address"); // RULE10

    property p_addr16;
        start && cfg_in.width16
            |=> mem_addr_out == {1'b0, $past(haddr_in[25:1])};
    endproperty
    a_addr16: assert property (p_addr16) else $error("16-bit addr"); // RULE11

    property p_split8;
        start && !cfg_in.width16 && (hsize_in == 3'h2) |=> last_q == 2'h3;
    endproperty
    a_split8: assert property (p_split8) else $error("word split"); // RULE19

    property p_single;
        start && cfg_in.width16 && (hsize_in == 3'h1) |=> last_q == 2'h0;
    endproperty
    a_single: assert property (p_single) else $error("half split"); // RULE5

    property p_back;
        step_piece |=> !sub_static_bank_sel_n_out && !addr_valid_n_out;
    endproperty
    a_back: assert property (p_back) else $error("split gap"); // RULE6

    property p_wait;
        (state_q == S_DSET) && t_done && wait_hold
            |=> (state_q == S_DSET)
                && !(mem_read_strobe_n_out && mem_write_strobe_n_out);
    endproperty
    a_wait: assert property (p_wait) else $error("wait ignored"); // RULE20

    property p_stall;
        !sub_static_bank_sel_n_out |-> !hreadyout_out;
    endproperty
    a_stall: assert property (p_stall) else $error("no stall"); // RULE21

    property p_strobe_cs;
        !mem_read_strobe_n_out || !mem_write_strobe_n_out
            |-> !sub_static_bank_sel_n_out
                && (mem_read_strobe_n_out || mem_write_strobe_n_out);
    endproperty
    a_strobe_cs: assert property (p_strobe_cs) else $error("strobe"); // RULE17

    property p_mux;
        !addr_valid_n_out && mux_on
            |-> mem_addr_data_oe_out
                && (mem_addr_data_out == mem_addr_out[15:0]);
    endproperty
    a_mux: assert property (p_mux) else $error("mux address"); // RULE12

    c_word8: cover property (start && !cfg_in.width16
                             && (hsize_in == 3'h2) && !hwrite_in);
    c_lane_wr: cover property (start && narrow && hwrite_in);
    c_wait: cover property ((state_q == S_DSET) && t_done && wait_hold);
    c_err: cover property (state_q == S_ERR1);

endmodule : ext_mem_ctrl

/* File: sim/static_mem_model.sv */
// behavioural asynchronous static memory beside the controller
`timescale 1ns/10ps

module static_mem_model (
    input  wire logic        core_clk_in,
    input  wire logic        width16_in,
    input  wire logic        mux_in,
    input  wire logic [3:0]  stall_in,
    input  wire logic [25:0] mem_addr_in,
    input  wire logic [15:0] bus_in,
    input  wire logic        sel_n_in,
    input  wire logic        rd_n_in,
    input  wire logic        wr_n_in,
    input  wire logic        latch_n_in,
    input  wire logic [1:0]  lane_n_in,
    output logic      [15:0] drive_out,
    output logic             wait_n_out
);
    logic [7:0]  mem [0:63];
    logic [25:0] lat_q;
    logic [25:0] wa;
    logic [5:0]  ba;
    logic [3:0]  cnt_q;
    logic [15:0] last_q;
    logic        strobe;

    initial for (int i = 0; i < 64; i++) mem[i] = 8'h00;

    // ========================================================
    // address: latched off the shared bus when multiplexed
    assign wa = mux_in ? lat_q : mem_addr_in;
    assign ba = width16_in ? {wa[4:0], 1'b0} : wa[5:0];
    always @(posedge core_clk_in)
        if (!latch_n_in) lat_q <= {mem_addr_in[25:16], bus_in};

    // ========================================================
    // data: released bus toggles so stale data never passes
    assign strobe = !rd_n_in || !wr_n_in;
    assign drive_out = (!sel_n_in && !rd_n_in) ?
        (width16_in ? {mem[ba | 6'h01], mem[ba]} : {~last_q[15:8], mem[ba]})
        : ~last_q;
    always @(posedge core_clk_in) begin
        last_q <= drive_out;
        if (!sel_n_in && !wr_n_in) begin
            if (!lane_n_in[0] || !width16_in) mem[ba] <= bus_in[7:0];
            if (!lane_n_in[1] && width16_in) mem[ba | 6'h01] <= bus_in[15:8];
        end
    end

    // ========================================================
    // wait: held low for stall_in cycles of each strobe
    always @(posedge core_clk_in) cnt_q <= strobe ? cnt_q + 4'h1 : 4'h0;
    assign wait_n_out = !(strobe && cnt_q < stall_in);
endmodule : static_mem_model

/* File: sim/test_external_static_memory_ctrl.sv */
// self-checking bench for the static memory controller
`timescale 1ns/10ps

module test_external_static_memory_ctrl;
    import ext_mem_pkg::*;
    typedef struct packed {
        logic        w16;
        logic        wr;
        logic [2:0]  sz;
        logic [31:0] a;
        logic [31:0] d;
    } row_t;
    logic        core_clk_in, rst_in, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, lane_n;
    logic [2:0]  hsize;
    mem_cfg_t    cfg;
    mem_timing_t rd_tim, wr_tim;
    logic [25:0] mem_addr, last_a;
    logic [15:0] ad_out, ad_bus, drive;
    logic        ad_oe, sel_n, rd_n, wr_n, adv_n, wait_n, rs;
    logic [3:0]  stall;
    int          miscompares, check_count, adv_cnt, n, pcs;
    realtime     t_edge;
    row_t        r;
    row_t        rows [10] = '{
        '{1'b1, 1'b1, 3'h2, 32'h0000_0010, 32'hA1B2_C3D4},
        '{1'b1, 1'b0, 3'h2, 32'h0000_0010, 32'hA1B2_C3D4},
        '{1'b1, 1'b0, 3'h1, 32'h0000_0012, 32'hA1B2_0000},
        '{1'b1, 1'b1, 3'h0, 32'h0000_0011, 32'h0000_5E00},
        '{1'b1, 1'b0, 3'h2, 32'h0000_0010, 32'hA1B2_5ED4},
        '{1'b0, 1'b1, 3'h2, 32'h0000_0020, 32'h1122_3344},
        '{1'b0, 1'b0, 3'h0, 32'h0000_0023, 32'h1100_0000},
        '{1'b0, 1'b1, 3'h1, 32'h0000_0026, 32'h7788_0000},
        '{1'b0, 1'b0, 3'h2, 32'h0000_0024, 32'h7788_0000},
        '{1'b0, 1'b0, 3'h2, 32'h0000_0020, 32'h1122_3344}};

    assign ad_bus = ad_oe ? ad_out : drive;

    ext_mem_ctrl i_dut (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
        .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
        .cfg_in(cfg), .rd_tim_in(rd_tim), .wr_tim_in(wr_tim),
        .mem_addr_out(mem_addr), .mem_addr_data_out(ad_out),
        .mem_addr_data_oe_out(ad_oe), .mem_addr_data_in(ad_bus),
        .sub_static_bank_sel_n_out(sel_n), .mem_read_strobe_n_out(rd_n),
        .mem_write_strobe_n_out(wr_n), .addr_valid_n_out(adv_n),
        .mem_byte_lane_n_out(lane_n), .mem_wait_n_in(wait_n));

    static_mem_model i_mem (
        .core_clk_in(core_clk_in), .width16_in(cfg.width16),
        .mux_in(cfg.mux_en), .stall_in(stall), .mem_addr_in(mem_addr),
        .bus_in(ad_bus), .sel_n_in(sel_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .latch_n_in(adv_n), .lane_n_in(lane_n), .drive_out(drive),
        .wait_n_out(wait_n));

    // ========================================================
    // clock, monitors
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) t_edge = $realtime;
    always @(posedge core_clk_in) if (!adv_n) last_a <= mem_addr;
    always @(negedge adv_n) adv_cnt++;
    always @(sel_n or rd_n or wr_n or adv_n or lane_n)
        if ($realtime > 0) check_val($realtime == t_edge, 1);

    // ========================================================
    // tasks
    task automatic check_val(input logic [31:0] got, exp,
                             input logic [31:0] m = 32'hFFFF_FFFF);
        check_count++;
        if ((got & m) !== (exp & m)) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got & m, exp & m);
        end
    endtask : check_val

    // entered just after an edge; returns in the cycle ready is high
    task automatic xfer(input logic wr, input logic [2:0] sz,
                        input logic [31:0] a, d);
        hsel = 1'b1;
        htrans = 2'b10;
        hwrite = wr;
        hsize = sz;
        haddr = a;
        n = 0;
        adv_cnt = 0;
        @(posedge core_clk_in);
        #1;
        hsel = 1'b0;
        htrans = 2'b00;
        hwdata = d;
        while (hreadyout !== 1'b1 && n < 2000) begin
            @(posedge core_clk_in);
            #1;
            n++;
        end
        rs = hresp;
        rd = hrdata;
    endtask : xfer

    function automatic int cyc(logic wr, int p, logic mx, int w);
        mem_timing_t t;
        t = wr ? wr_tim : rd_tim;
        return p * (t.aset + 1 + (mx ? t.ahld + 1 : 0) + t.dset + 1 + w)
               + (wr ? 0 : t.buslat + 1);
    endfunction : cyc

    function automatic logic [31:0] lanes(logic [2:0] sz, logic [1:0] a);
        if (sz == 3'h0) return 32'h0000_00FF << (8 * a);
        if (sz == 3'h1) return 32'h0000_FFFF << (16 * a[1]);
        return 32'hFFFF_FFFF;
    endfunction : lanes

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #125000;
        miscompares++;
        summarize();
    end

    // ========================================================
    // main sequence
    initial begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata, stall} = '0;
        cfg = '{1'b1, MT_SRAM, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        // reads slower than writes so a timing mix-up shows
        rd_tim = '{4'h1, 4'h1, 8'h02, 4'h1};
        wr_tim = '{4'h0, 4'h2, 8'h01, 4'h0};
        rst_in = 1'b1;
        repeat (2) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        for (int i = 0; i < 10; i++) begin
            r = rows[i];
            cfg.width16 = r.w16;
            pcs = r.w16 ? (r.sz == 3'h2 ? 2 : 1) : (1 << r.sz);
            xfer(r.wr, r.sz, r.a, r.d);
            check_val(n, cyc(r.wr, pcs, 0, 0));
            check_val(adv_cnt, pcs);
            check_val(rs, 0);
            check_val(last_a, r.w16 ? (r.a[25:0] + 2 * (pcs - 1)) >> 1
                              : r.a[25:0] + pcs - 1);
            if (!r.wr) check_val(rd, r.d, lanes(r.sz, r.a[1:0]));
            $display("row %0d done", i);
        end
        // the row loop ends on an 8-bit row; the rest runs 16-bit
        cfg.width16 = 1'b1;
        for (int k = 0; k < 5; k++) begin
            cfg.bank_en = (k != 4);
            cfg.wr_en = (k != 2);
            cfg.mem_type = (k >= 3) ? MT_NOR : MT_SRAM;
            xfer(k >= 2, k == 1 ? 3'h3 : (k == 3 ? 3'h0 : 3'h1),
                 k == 0 ? 32'h0400_0010 : 32'h0000_0010, 32'h0);
            check_val(rs, 1);
            check_val(adv_cnt, 0);
        end
        cfg.wr_en = 1'b1;
        cfg.bank_en = 1'b1;
        $display("refusal test done");
        cfg.wait_en = 1'b1;
        stall = 4'h5;
        xfer(1'b0, 3'h1, 32'h0000_0012, 32'h0);
        check_val(n, cyc(0, 1, 0, 3));
        check_val(rd, 32'hA1B2_0000, 32'hFFFF_0000);
        stall = 4'h0;
        cfg.wait_en = 1'b0;
        $display("wait test done");
        cfg.mux_en = 1'b1;
        cfg.mem_type = MT_PSRAM;
        xfer(1'b1, 3'h1, 32'h0000_0030, 32'h0000_BEEF);
        check_val(n, cyc(1, 1, 1, 0));
        xfer(1'b0, 3'h1, 32'h0000_0030, 32'h0);
        check_val(n, cyc(0, 1, 1, 0));
        check_val(rd, 32'h0000_BEEF, 32'h0000_FFFF);
        cfg.mux_en = 1'b0;
        cfg.mem_type = MT_SRAM;
        $display("multiplex test done");
        rst_in = 1'b1;
        repeat (2) @(posedge core_clk_in);
        #1;
        check_val({sel_n, rd_n, wr_n, lane_n, ad_oe, hreadyout, hresp},
                  8'hFA);
        rst_in = 1'b0;
        xfer(1'b0, 3'h2, 32'h0000_0010, 32'h0);
        check_val(rd, 32'hA1B2_5ED4);
        $display("reset test done");
        summarize();
    end
endmodule : test_external_static_memory_ctrl
